/* File: pkg/cpu_regs_map.vh */
// Register indices, field positions, resets and steps of the bank.
// Assumes inclusion by bare name inside a module; byte address = 4 * index.
`ifndef CPU_REGS_MAP_VH
`define CPU_REGS_MAP_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define RI_ACC_D      5'h00
`define RI_ACC_E      5'h01
`define RI_IDX_ONE    5'h02
`define RI_IDX_TWO    5'h03
`define RI_IDX_THREE  5'h04
`define RI_STACK_PTR  5'h05
`define RI_PROG_CNT   5'h06
`define RI_FLAGS      5'h07
`define RI_BANKS      5'h08
`define RI_STACK_BANK 5'h09
`define RI_MAC_MULT   5'h0a
`define RI_MAC_CAND   5'h0b
`define RI_MAC_LO     5'h0c
`define RI_MAC_HI     5'h0d
`define RI_MOD_MASKS  5'h0e
`define RI_MAC_RND    5'h0f
`define RI_MAC_TRN    5'h10
`define RI_ACC_A      5'h11
`define RI_ACC_B      5'h12
`define RI_COUNT      5'h13

// ----------------------------------------
// Flag word fields
// ----------------------------------------
`define FL_STOP       15
`define FL_MF         14
`define FL_H          13
`define FL_XF         12
`define FL_N          11
`define FL_Z          10
`define FL_V          9
`define FL_C          8
`define FL_IM_HI      7
`define FL_IM_LO      5
`define FL_ST         4
`define FL_PB_HI      3
`define FL_PB_LO      0
`define FLAGS_RST     16'h00e0

// ----------------------------------------
// Bank extension register and reset-vector bank word layout
// ----------------------------------------
`define BK_EB_HI      15
`define BK_EB_LO      12
`define BK_B1_HI      11
`define BK_B1_LO      8
`define BK_B2_HI      7
`define BK_B2_LO      4
`define BK_B3_HI      3
`define BK_B3_LO      0
`define VB_B3_HI      11
`define VB_B3_LO      8
`define VB_SB_HI      7
`define VB_SB_LO      4
`define VB_PB_HI      3
`define VB_PB_LO      0

// ----------------------------------------
// Reset vector load selects and address steps
// ----------------------------------------
`define VL_BANKS      2'h0
`define VL_PC         2'h1
`define VL_SP         2'h2
`define VL_I3         2'h3
`define STEP_WORD     20'h00002
`define STEP_BYTE     20'h00001
`define SAT_POS       16'h7fff
`define SAT_NEG       16'h8000

`endif

/* File: tb/cpu_register_bank_chk.sv */
// Checker for APB timing and bus request relations of the bank.
// Assumes binding into cpu_register_bank; one clock, async reset.
`timescale 1ns/1ps
module cpu_register_bank_chk (
   // Clock and reset
   input logic        core_clk,
   input logic        arst_n,
   // Requests
   input logic        psel,
   input logic        penable,
   input logic        fetchReq,
   input logic        stkPush,
   input logic        vecReq,
   input logic [7:0]  vecNum,
   input logic        haltExec,
   input logic        wakeUp,
   input logic        irqReq,
   input logic [2:0]  irqLevel,
   // Answers
   input logic        pready,
   input logic        busValid_q,
   input logic [23:0] busAddr_q,
   input logic        busProgSpace_q,
   input logic        busWrite_q,
   input logic        clkStop_q,
   input logic        irqAccept_q
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_two_fetch;
      fetchReq ##1 fetchReq;
   endsequence
   a_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   a_top_copy: assert property (
      busValid_q |-> busAddr_q[23:20] == {4{busAddr_q[19]}})
      else $error("top address bits wrong");
   a_fetch_align: assert property (
      fetchReq |=> busValid_q && busProgSpace_q && !busAddr_q[0])
      else $error("fetch not aligned program access");
   a_vec_space: assert property (vecReq && !fetchReq |=>
      busProgSpace_q == ($past(vecNum) == 8'h00) &&
      busAddr_q[8:0] == {$past(vecNum), 1'b0})
      else $error("vector access wrong");
   a_fetch_step: assert property (s_two_fetch |=>
      busAddr_q[19:0] == $past(busAddr_q[19:0]) + 20'h00002)
      else $error("fetch step wrong");
   a_push_write: assert property (
      stkPush && !fetchReq && !vecReq |=> busWrite_q && !busProgSpace_q)
      else $error("push not a data write");
   a_wake_clear: assert property (
      wakeUp && !haltExec |=> !clkStop_q) else $error("wake did not restart");
   a_irq_masked: assert property (
      !irqReq || irqLevel == 3'h0 |=> !irqAccept_q)
      else $error("interrupt accepted below mask");
endmodule
bind cpu_register_bank cpu_register_bank_chk chk_u (.*);

/* File: tb/module_bus_model.sv */
// Far side of the internal module bus: logs every request in order.
// Assumes single-cycle request pulses that need no answer.
`timescale 1ns/1ps
module module_bus_model (
   // Clock
   input logic        core_clk,
   // Request
   input logic        busValid_q,
   input logic [23:0] busAddr_q,
   input logic        busProgSpace_q,
   input logic        busByte_q,
   input logic        busWrite_q
);
   // Entry is {program space, byte, write, address}.
   logic [26:0] seen[$];
   always @(posedge core_clk) begin
      if (busValid_q === 1'b1)
         seen.push_back({busProgSpace_q, busByte_q, busWrite_q, busAddr_q});
   end
endmodule

/* File: tb/test_cpu_register_bank.sv */
// Self-checking bench: APB register access, bus addresses, flags, MAC.
// Assumes the bus model and checker files are compiled before it.
`timescale 1ns/1ps
module test_cpu_register_bank;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, exWrEn, er, mh;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, exWrData, exRdData_q, rd;
   logic [4:0]  exWrSel, exRdSel;
   logic        aluUpd, aluWord, aluCarry, aluOvf, aluBcd, aluHalf;
   logic [15:0] aluResult, dataOffset, vecLoadData, msp, r;
   logic        macUpd, macOvf35, macOvf31, fetchReq, stkPush, stkPull;
   logic [35:0] macResult;
   logic        stkByte, idxInc, idxWord, dataReq, dataByte, dataWrite;
   logic [1:0]  idxSel, dataSel, vecLoadSel;
   logic        vecReq, vecLoad, haltExec, wakeUp, irqReq;
   logic [7:0]  vecNum;
   logic [2:0]  irqLevel;
   logic [4:0]  c;
   logic        busValid_q, busProgSpace_q, busByte_q, busWrite_q;
   logic        clkStop_q, irqAccept_q;
   logic [23:0] busAddr_q;
   int          err_count = 0;
   int          comparisons = 0;
   cpu_register_bank dut_u (.*);
   module_bus_model bus_u (.*);
   always #5 core_clk = ~core_clk;
   function automatic logic [23:0] ext(input logic [19:0] a);
      return {{4{a[19]}}, a};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Entered just after a rising edge; leaves one idle edge after the answer.
   task automatic apb(input logic w, input logic [4:0] i,
                      input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 5'h0, i, 2'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge core_clk);
   endtask
   task automatic rreg(input logic [4:0] i, input logic [31:0] exp);
      apb(1'b0, i, 32'h0);
      check(rd, exp);
   endtask
   task automatic busChk(input logic [26:0] exp);
      logic [26:0] got;
      repeat (2) @(posedge core_clk);
      got = (bus_u.seen.size() > 0) ? bus_u.seen.pop_front() : 27'h0;
      check({5'h00, got}, {5'h00, exp});
   endtask
   task automatic stk(input logic push, input logic byt);
      {stkPush, stkPull, stkByte} <= {push, !push, byt};
      @(posedge core_clk);
      {stkPush, stkPull} <= 2'b00;
      if (!push) msp = msp + (byt ? 16'h1 : 16'h2);
      busChk({1'b0, byt, push, ext({4'h6, msp})});
      if (push) msp = msp - (byt ? 16'h1 : 16'h2);
   endtask
   task automatic data(input logic [1:0] s, input logic [15:0] o);
      {dataReq, dataSel, dataOffset, dataByte, dataWrite} <=
         {1'b1, s, o, o[1:0]};
      @(posedge core_clk);
      dataReq <= 1'b0;
   endtask
   task automatic halt(input logic w, input logic exp);
      {haltExec, wakeUp} <= {!w, w};
      @(posedge core_clk);
      {haltExec, wakeUp} <= 2'b00;
      @(posedge core_clk);
      check({31'h0, clkStop_q}, {31'h0, exp});
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, exWrEn, exWrSel, exWrData,
       exRdSel, aluUpd, aluWord, aluResult, aluCarry, aluOvf, aluBcd, aluHalf,
       macUpd, macResult, macOvf35, macOvf31, fetchReq, stkPush, stkPull,
       stkByte, idxInc, idxSel, idxWord, dataReq, dataSel, dataOffset,
       dataByte, dataWrite, vecReq, vecNum, vecLoad, vecLoadSel, vecLoadData,
       haltExec, wakeUp, irqReq, irqLevel, mh} = 0;
      msp = 16'h0101;
      void'($urandom(18860));
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      rreg(5'h07, 32'h00e0);
      rreg(5'h13, 32'h0);
      check({31'h0, er}, 32'h1);
      r = 16'($urandom);
      apb(1'b1, 5'h11, {24'h0, r[15:8]});
      apb(1'b1, 5'h12, {24'h0, r[7:0]});
      rreg(5'h00, {16'h0, r});
      apb(1'b1, 5'h00, {16'h0, ~r});
      rreg(5'h11, {24'h0, ~r[15:8]});
      apb(1'b1, 5'h08, 32'h0000abcd);
      {vecLoad, vecLoadData} <= {1'b1, 16'h0567};
      @(posedge core_clk);
      {vecLoadSel, vecLoadData} <= {2'h3, 16'hfffe};
      @(posedge core_clk);
      vecLoad <= 1'b0;
      rreg(5'h08, 32'h0000abc5);
      rreg(5'h09, 32'h6);
      rreg(5'h07, 32'h00e7);
      {idxInc, idxSel, idxWord} <= 4'hf;
      @(posedge core_clk);
      idxInc <= 1'b0;
      rreg(5'h08, 32'h0000abc6);
      rreg(5'h04, 32'h0);
      apb(1'b1, 5'h06, 32'h0000ffff);
      fetchReq <= 1'b1;
      repeat (2) @(posedge core_clk);
      fetchReq <= 1'b0;
      busChk({3'b100, ext(20'h7fffe)});
      busChk({3'b100, ext(20'h80000)});
      rreg(5'h07, 32'h00e8);
      apb(1'b1, 5'h05, {16'h0, msp});
      stk(1'b1, 1'b0);
      stk(1'b1, 1'b1);
      stk(1'b0, 1'b1);
      stk(1'b0, 1'b0);
      rreg(5'h05, {16'h0, msp});
      r = 16'($urandom);
      data(2'h0, r);
      busChk({1'b0, r[1:0], ext({4'ha, r})});
      apb(1'b1, 5'h02, 32'h0000fff0);
      data(2'h1, 16'h0021);
      busChk({3'b001, ext(20'hc0011)});
      for (int v = 0; v < 6; v += 5) begin
         {vecReq, vecNum} <= {1'b1, 8'(v)};
         @(posedge core_clk);
         vecReq <= 1'b0;
         busChk({v == 0, 2'b00, ext({11'h0, 8'(v), 1'b0})});
      end
      for (int i = 0; i < 5; i++) begin
         r = (i == 0) ? 16'h0 : 16'($urandom);
         c = 5'($urandom);
         {aluUpd, aluWord, aluResult, aluCarry, aluOvf, aluBcd, aluHalf} <=
            {1'b1, c[4], r, c[3:0]};
         @(posedge core_clk);
         aluUpd <= 1'b0;
         if (c[1]) mh = c[0];
         rreg(5'h07, {16'h0, 2'b00, mh, 1'b0, c[4] ? r[15] : r[7],
            c[4] ? r == 16'h0 : r[7:0] == 8'h0, c[2], c[3],
            8'he8});
      end
      apb(1'b1, 5'h07, 32'h00e8);
      {macUpd, macResult} <= {1'b1, 36'h800012345};
      @(posedge core_clk);
      {macOvf35, macOvf31} <= 2'b11;
      @(posedge core_clk);
      {macUpd, macOvf35, macOvf31} <= 3'h0;
      rreg(5'h10, 32'h0001);
      rreg(5'h0d, 32'h8);
      rreg(5'h07, 32'h50e8);
      apb(1'b1, 5'h07, 32'h50f8);
      rreg(5'h10, 32'h8000);
      rreg(5'h0f, 32'h8000);
      halt(1'b0, 1'b1);
      halt(1'b1, 1'b0);
      apb(1'b1, 5'h07, 32'h8068);
      halt(1'b0, 1'b0);
      for (int l = 0; l < 8; l++) begin
         {irqReq, irqLevel} <= {1'b1, 3'(l)};
         repeat (2) @(posedge core_clk);
         check({31'h0, irqAccept_q}, {31'h0, l > 3});
      end
      exRdSel <= 5'h07;
      repeat (2) @(posedge core_clk);
      check(exRdData_q, 32'h8068);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      summarize();
   end
endmodule

/* File: verilog/cpu_register_bank.v */
// Register bank and 20-bit bank addressing of a 16-bit core, APB slave.
// Assumes one clock shared with the execution unit's strobes.
//
// Behaviour
// RULE1 - Two byte accumulators, word accumulator, joined pair.
// RULE2 - Three index registers, each with bank field.
// RULE3 - Reset vector loads third index and bank.
// RULE4 - Stack decrements on push, increments on pull.
// RULE5 - Stack pointer addresses next free location.
// RULE6 - Byte stack steps and odd pointers allowed.
// RULE7 - Fetch address forces bit zero low.
// RULE8 - Flag word field layout fixed.
// RULE9 - Halt stops clock unless stop enable set.
// RULE10 - Full MAC overflow flag on bit 35.
// RULE11 - MAC extension overflow flag on bit 31.
// RULE12 - Half carry from BCD addition.
// RULE13 - Negative flag from most significant bit.
// RULE14 - Zero flag when all bits zero.
// RULE15 - Overflow flag on two's complement overflow.
// RULE16 - Carry flag on carry, borrow, shifts.
// RULE17 - Interrupt mask level masks requests.
// RULE18 - Saturated MAC reads when overflow flagged.
// RULE19 - Six bank fields in three places.
// RULE20 - MAC multiplier, multiplicand, accumulator, modulo masks.
// RULE21 - Sixteen 64 Kbyte banks, bank field selects.
// RULE22 - Program or data space signalled per access.
// RULE23 - Address bit 19 copied to bus bits 23..20.
// RULE24 - Sequential increments carry into bank field.
`timescale 1ns/1ps

module cpu_register_bank (
   // Clock and reset
   input  wire        core_clk,
   input  wire        arst_n,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Execution unit register port
   input  wire        exWrEn,
   input  wire [4:0]  exWrSel,
   input  wire [31:0] exWrData,
   input  wire [4:0]  exRdSel,
   output reg  [31:0] exRdData_q,
   // Flag updates
   input  wire        aluUpd,
   input  wire        aluWord,
   input  wire [15:0] aluResult,
   input  wire        aluCarry,
   input  wire        aluOvf,
   input  wire        aluBcd,
   input  wire        aluHalf,
   input  wire        macUpd,
   input  wire [35:0] macResult,
   input  wire        macOvf35,
   input  wire        macOvf31,
   // Address generation requests
   input  wire        fetchReq,
   input  wire        stkPush,
   input  wire        stkPull,
   input  wire        stkByte,
   input  wire        idxInc,
   input  wire [1:0]  idxSel,
   input  wire        idxWord,
   input  wire        dataReq,
   input  wire [1:0]  dataSel,
   input  wire [15:0] dataOffset,
   input  wire        dataByte,
   input  wire        dataWrite,
   input  wire        vecReq,
   input  wire [7:0]  vecNum,
   input  wire        vecLoad,
   input  wire [1:0]  vecLoadSel,
   input  wire [15:0] vecLoadData,
   // Halt and interrupts
   input  wire        haltExec,
   input  wire        wakeUp,
   input  wire        irqReq,
   input  wire [2:0]  irqLevel,
   // Internal module bus request
   output reg         busValid_q,
   output reg  [23:0] busAddr_q,
   output reg         busProgSpace_q,
   output reg         busByte_q,
   output reg         busWrite_q,
   // Core status
   output reg         clkStop_q,
   output reg         irqAccept_q
);

`include "cpu_regs_map.vh"

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg  [7:0]  accA_q;
   reg  [7:0]  accB_q;
   reg  [15:0] accE_q;
   reg  [15:0] idxOne_q;
   reg  [15:0] idxTwo_q;
   reg  [15:0] idxThree_q;
   reg  [3:0]  idxOneBank_q;
   reg  [3:0]  idxTwoBank_q;
   reg  [3:0]  idxThreeBank_q;
   reg  [3:0]  extModeBank_q;
   reg  [3:0]  stackBank_q;
   reg  [15:0] stackPtr_q;
   reg  [15:0] progCnt_q;
   reg  [15:0] flags_q;
   reg  [15:0] macMult_q;
   reg  [15:0] macCand_q;
   reg  [35:0] macAccum_q;
   reg         macSignPre_q;
   reg  [7:0]  modMaskOne_q;
   reg  [7:0]  modMaskTwo_q;

   // ----------------------------------------
   // Derived values
   // ----------------------------------------
   wire [4:0]  apbSel    = paddr[6:2];
   wire        apbMapped = (paddr[11:7] == 5'h00) &&
                           (paddr[1:0] == 2'h0) && (apbSel < `RI_COUNT);
   wire        apbWr     = psel & penable & pready & pwrite & apbMapped;
   // The execution unit wins a same-cycle write; the APB write is lost.
   wire        wrEn      = exWrEn | apbWr;
   wire [4:0]  wrSel     = exWrEn ? exWrSel : apbSel;
   wire [31:0] wrData    = exWrEn ? exWrData : pwdata;

   wire [19:0] progAddr  = {flags_q[`FL_PB_HI:`FL_PB_LO], progCnt_q};
   wire [19:0] fetchAddr = {progAddr[19:1], 1'b0};            // [RULE7]
   wire [19:0] fetchNext = fetchAddr + `STEP_WORD;            // [RULE24]
   wire [19:0] stackAddr = {stackBank_q, stackPtr_q};         // [RULE5]
   wire [19:0] stackStep = stkByte ? `STEP_BYTE : `STEP_WORD; // [RULE6]
   wire [19:0] stackDown = stackAddr - stackStep;             // [RULE4]
   wire [19:0] stackUp   = stackAddr + stackStep;             // [RULE4]
   wire [19:0] idxStep   = idxWord ? `STEP_WORD : `STEP_BYTE;
   wire [19:0] idxOneA   = {idxOneBank_q, idxOne_q};          // [RULE2]
   wire [19:0] idxTwoA   = {idxTwoBank_q, idxTwo_q};
   wire [19:0] idxThreeA = {idxThreeBank_q, idxThree_q};
   wire [19:0] idxOneN   = idxOneA + idxStep;                 // [RULE24]
   wire [19:0] idxTwoN   = idxTwoA + idxStep;
   wire [19:0] idxThreeN = idxThreeA + idxStep;

   wire [15:0] macTrunc  = macAccum_q[31:16];
   wire [16:0] macRndSum = {1'b0, macTrunc} + {16'h0000, macAccum_q[15]};
   wire        macSat    = flags_q[`FL_ST] &
                           (flags_q[`FL_MF] | flags_q[`FL_XF]);
   wire [15:0] macSatVal = macSignPre_q ? `SAT_NEG : `SAT_POS;
   wire [15:0] macRdRnd  = macSat ? macSatVal : macRndSum[15:0]; // [RULE18]
   wire [15:0] macRdTrn  = macSat ? macSatVal : macTrunc;     // [RULE18]

   wire        aluMsb    = aluWord ? aluResult[15] : aluResult[7];
   wire        aluZero   = aluWord ? (aluResult == 16'h0000) :
                           (aluResult[7:0] == 8'h00);

   // Register selects used by both the APB and the execution unit.
   function [31:0] readReg;
      input [4:0] s;
      begin
         case (s)
            `RI_ACC_D:      readReg = {16'h0000, accA_q, accB_q}; // [RULE1]
            `RI_ACC_E:      readReg = {16'h0000, accE_q};
            `RI_IDX_ONE:    readReg = {16'h0000, idxOne_q};
            `RI_IDX_TWO:    readReg = {16'h0000, idxTwo_q};
            `RI_IDX_THREE:  readReg = {16'h0000, idxThree_q};
            `RI_STACK_PTR:  readReg = {16'h0000, stackPtr_q};
            `RI_PROG_CNT:   readReg = {16'h0000, progCnt_q};
            `RI_FLAGS:      readReg = {16'h0000, flags_q};        // [RULE8]
            `RI_BANKS:      readReg = {16'h0000, extModeBank_q,
                                       idxOneBank_q, idxTwoBank_q,
                                       idxThreeBank_q};           // [RULE19]
            `RI_STACK_BANK: readReg = {28'h0000000, stackBank_q};
            `RI_MAC_MULT:   readReg = {16'h0000, macMult_q};      // [RULE20]
            `RI_MAC_CAND:   readReg = {16'h0000, macCand_q};
            `RI_MAC_LO:     readReg = macAccum_q[31:0];
            `RI_MAC_HI:     readReg = {28'h0000000, macAccum_q[35:32]};
            `RI_MOD_MASKS:  readReg = {16'h0000, modMaskOne_q,
                                       modMaskTwo_q};
            `RI_MAC_RND:    readReg = {16'h0000, macRdRnd};
            `RI_MAC_TRN:    readReg = {16'h0000, macRdTrn};
            `RI_ACC_A:      readReg = {24'h000000, accA_q};
            `RI_ACC_B:      readReg = {24'h000000, accB_q};
            default:        readReg = 32'h00000000;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Register bank update
   // ----------------------------------------
   // Later assignments win: hardware updates override a same-cycle
   // write, so a flag set by an event is never lost to a clear.
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         accA_q         <= 8'h00;
         accB_q         <= 8'h00;
         accE_q         <= 16'h0000;
         idxOne_q       <= 16'h0000;
         idxTwo_q       <= 16'h0000;
         idxThree_q     <= 16'h0000;
         idxOneBank_q   <= 4'h0;
         idxTwoBank_q   <= 4'h0;
         idxThreeBank_q <= 4'h0;
         extModeBank_q  <= 4'h0;
         stackBank_q    <= 4'h0;
         stackPtr_q     <= 16'h0000;
         progCnt_q      <= 16'h0000;
         flags_q        <= `FLAGS_RST;
         macMult_q      <= 16'h0000;
         macCand_q      <= 16'h0000;
         macAccum_q     <= 36'h000000000;
         macSignPre_q   <= 1'b0;
         modMaskOne_q   <= 8'h00;
         modMaskTwo_q   <= 8'h00;
         clkStop_q      <= 1'b0;
         irqAccept_q    <= 1'b0;
      end else begin
         if (wrEn) begin
            case (wrSel)
               `RI_ACC_D: begin                                   // [RULE1]
                  accA_q <= wrData[15:8];
                  accB_q <= wrData[7:0];
               end
               `RI_ACC_A:      accA_q     <= wrData[7:0];
               `RI_ACC_B:      accB_q     <= wrData[7:0];
               `RI_ACC_E:      accE_q     <= wrData[15:0];
               `RI_IDX_ONE:    idxOne_q   <= wrData[15:0];
               `RI_IDX_TWO:    idxTwo_q   <= wrData[15:0];
               `RI_IDX_THREE:  idxThree_q <= wrData[15:0];
               `RI_STACK_PTR:  stackPtr_q <= wrData[15:0];        // [RULE6]
               `RI_PROG_CNT:   progCnt_q  <= wrData[15:0];
               `RI_FLAGS:      flags_q    <= wrData[15:0];
               `RI_BANKS: begin                                   // [RULE19]
                  extModeBank_q  <= wrData[`BK_EB_HI:`BK_EB_LO];
                  idxOneBank_q   <= wrData[`BK_B1_HI:`BK_B1_LO];
                  idxTwoBank_q   <= wrData[`BK_B2_HI:`BK_B2_LO];
                  idxThreeBank_q <= wrData[`BK_B3_HI:`BK_B3_LO];
               end
               `RI_STACK_BANK: stackBank_q <= wrData[3:0];
               `RI_MAC_MULT:   macMult_q   <= wrData[15:0];       // [RULE20]
               `RI_MAC_CAND:   macCand_q   <= wrData[15:0];
               `RI_MAC_LO:     macAccum_q[31:0]  <= wrData;
               `RI_MAC_HI:     macAccum_q[35:32] <= wrData[3:0];
               `RI_MOD_MASKS: begin
                  modMaskOne_q <= wrData[15:8];
                  modMaskTwo_q <= wrData[7:0];
               end
               default: ;
            endcase
         end
         if (vecLoad) begin
            case (vecLoadSel)
               `VL_BANKS: begin                                   // [RULE3]
                  idxThreeBank_q <= vecLoadData[`VB_B3_HI:`VB_B3_LO];
                  stackBank_q    <= vecLoadData[`VB_SB_HI:`VB_SB_LO];
                  flags_q[`FL_PB_HI:`FL_PB_LO] <=
                     vecLoadData[`VB_PB_HI:`VB_PB_LO];
               end
               `VL_PC:  progCnt_q  <= vecLoadData;
               `VL_SP:  stackPtr_q <= vecLoadData;
               `VL_I3:  idxThree_q <= vecLoadData;                // [RULE3]
               default: ;
            endcase
         end
         if (aluUpd) begin
            flags_q[`FL_N] <= aluMsb;                             // [RULE13]
            flags_q[`FL_Z] <= aluZero;                            // [RULE14]
            flags_q[`FL_V] <= aluOvf;                             // [RULE15]
            flags_q[`FL_C] <= aluCarry;                           // [RULE16]
            if (aluBcd)
               flags_q[`FL_H] <= aluHalf;                         // [RULE12]
         end
         if (macUpd) begin
            macAccum_q <= macResult;
            // Keep the sign seen before the first overflow for saturation.
            if ((macOvf35 | macOvf31) &
                !(flags_q[`FL_MF] | flags_q[`FL_XF]))
               macSignPre_q <= macAccum_q[35];                    // [RULE18]
            if (macOvf35)
               flags_q[`FL_MF] <= 1'b1;                           // [RULE10]
            if (macOvf31)
               flags_q[`FL_XF] <= 1'b1;                           // [RULE11]
         end
         if (fetchReq) begin
            progCnt_q <= fetchNext[15:0];                         // [RULE24]
            flags_q[`FL_PB_HI:`FL_PB_LO] <= fetchNext[19:16];
         end
         if (stkPush)
            {stackBank_q, stackPtr_q} <= stackDown;               // [RULE4]
         else if (stkPull)
            {stackBank_q, stackPtr_q} <= stackUp;                 // [RULE4]
         if (idxInc) begin
            case (idxSel)
               2'h1:    {idxOneBank_q, idxOne_q}     <= idxOneN;  // [RULE24]
               2'h2:    {idxTwoBank_q, idxTwo_q}     <= idxTwoN;
               2'h3:    {idxThreeBank_q, idxThree_q} <= idxThreeN;
               default: ;
            endcase
         end
         if (wakeUp)
            clkStop_q <= 1'b0;
         // With stop enable set the halt is a no-operation.
         if (haltExec & !flags_q[`FL_STOP])
            clkStop_q <= 1'b1;                                    // [RULE9]
         irqAccept_q <= irqReq &
                        (irqLevel > flags_q[`FL_IM_HI:`FL_IM_LO]); // [RULE17]
      end
   end

   // ----------------------------------------
   // Bus address generation
   // ----------------------------------------
   reg  [19:0] reqAddr;
   reg         reqProg;
   reg         reqByte;
   reg         reqWrite;
   reg         reqValid;

   always @* begin
      reqAddr  = 20'h00000;
      reqProg  = 1'b0;
      reqByte  = 1'b0;
      reqWrite = 1'b0;
      reqValid = 1'b1;
      if (fetchReq) begin
         reqAddr = fetchAddr;                                     // [RULE7]
         reqProg = 1'b1;                                          // [RULE22]
      end else if (vecReq) begin
         // Vectors live in bank 0; only the reset vector is program space.
         reqAddr = {11'h000, vecNum, 1'b0};
         reqProg = (vecNum == 8'h00);                             // [RULE22]
      end else if (stkPush) begin
         reqAddr  = stackAddr;                                    // [RULE5]
         reqByte  = stkByte;
         reqWrite = 1'b1;
      end else if (stkPull) begin
         reqAddr = stackUp;                                       // [RULE5]
         reqByte = stkByte;
      end else if (dataReq) begin
         case (dataSel)                                           // [RULE21]
            2'h1:    reqAddr = idxOneA + {4'h0, dataOffset};
            2'h2:    reqAddr = idxTwoA + {4'h0, dataOffset};
            2'h3:    reqAddr = idxThreeA + {4'h0, dataOffset};
            default: reqAddr = {extModeBank_q, dataOffset};
         endcase
         reqByte  = dataByte;
         reqWrite = dataWrite;
      end else begin
         reqValid = 1'b0;
      end
   end

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         busValid_q     <= 1'b0;
         busAddr_q      <= 24'h000000;
         busProgSpace_q <= 1'b0;
         busByte_q      <= 1'b0;
         busWrite_q     <= 1'b0;
         exRdData_q     <= 32'h00000000;
      end else begin
         busValid_q     <= reqValid;
         busAddr_q      <= {{4{reqAddr[19]}}, reqAddr};           // [RULE23]
         busProgSpace_q <= reqProg & reqValid;
         busByte_q      <= reqByte;
         busWrite_q     <= reqWrite;
         exRdData_q     <= readReg(exRdSel);
      end
   end

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state: read data is registered so every output is a flop.
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel & penable & !pready) begin
         pready  <= 1'b1;
         pslverr <= !apbMapped;
         prdata  <= (apbMapped & !pwrite) ? readReg(apbSel) : 32'h00000000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule
